// >>> sim/bbp_frame_ctrl_sva.sv
/* port checker of the frame controller
   assumes one mclk domain and bind to bbp_frame_ctrl */
`timescale 1ns/1ns
module bbp_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire bbp_pkg::bbp_bus_t hostBus,
  input wire bbp_pkg::bbp_line_t lineIn,
  input wire logic busDataOe,
  input wire logic serialOutput,
  input wire logic txBufferEmpty,
  input wire logic txUnderrunOutput,
  input wire logic rxStatusAvail,
  input wire logic receiverActive
);
  import bbp_pkg::*;
  wire logic rd = hostBus.chipEn && !hostBus.writeNotRead;
  wire logic rdHi = rd && hostBus.addr == 3'b001 && hostBus.byteSel;
  wire logic wrTx = hostBus.chipEn && hostBus.writeNotRead && hostBus.addr[2:1] == 2'b01;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_RESET: assert property ($fell(rst) |-> serialOutput && txBufferEmpty
    && !busDataOe && !rxStatusAvail && !receiverActive) else $error("bad reset state");
  AST_WR_EMPTY: assert property ($rose(lineIn.dataStrobe) && wrTx
    |-> ##[1:5] !txBufferEmpty) else $error("buffer empty not cleared");
  AST_HI_CLEAR: assert property ($fell(lineIn.dataStrobe) && rdHi
    |-> ##[1:6] !rxStatusAvail) else $error("status available not cleared");
  AST_HI_HOLD: assert property (lineIn.dataStrobe && rdHi && rxStatusAvail
    |=> rxStatusAvail) else $error("status cleared during read");
  AST_OE_READ: assert property ($rose(busDataOe)
    |-> $past(lineIn.dataStrobe) && !$past(hostBus.writeNotRead)) else $error("drive without read");
  AST_OE_DROP: assert property ($fell(lineIn.dataStrobe)
    |-> ##[1:5] !busDataOe) else $error("bus drive not released");
  AST_UNDERRUN: assert property ($rose(txUnderrunOutput)
    |-> txBufferEmpty && lineIn.txEnable) else $error("underrun with data loaded");
  AST_RX_OFF: assert property (!lineIn.rxEnable [*4]
    |=> !receiverActive && !rxStatusAvail) else $error("receiver flags with enable low");
  cover property ($rose(txUnderrunOutput));
  cover property ($rose(receiverActive));
  cover property ($fell(rxStatusAvail));
endmodule : bbp_chk
bind bbp_frame_ctrl bbp_chk chk_u (.mclk, .rst, .hostBus, .lineIn, .busDataOe, .serialOutput,
  .txBufferEmpty, .txUnderrunOutput, .rxStatusAvail, .receiverActive);

// >>> sim/bbp_station.sv
/* remote station model: bit clocks, received frames and capture of the line
   assumes 160 ns bit time, LSB first, receive clock still outside frames, transmit clock runs whenever txRun is set */
`timescale 1ns/1ns
module bbp_station (
  input wire logic serialOutput,
  input wire logic txRun,
  output logic txBitClock,
  output logic rxBitClock,
  output logic serialIn,
  output logic [7:0] txSeen
);
  int ones = 0;
  initial begin
    txBitClock = 1'b1;
    rxBitClock = 1'b0;
    serialIn = 1'b1;
    txSeen = 8'h00;
  end
  always begin
    #80;
    if (txRun) txBitClock = ~txBitClock;
  end
  always @(posedge txBitClock) txSeen <= {serialOutput, txSeen[7:1]};
  task automatic bitOut(input logic v);
    serialIn = v;
    #80 rxBitClock = 1'b1;
    #80 rxBitClock = 1'b0;
  endtask : bitOut
  // zero insertion after five ones when stuff is set
  task automatic sendBits(input logic [7:0] b, input int n, input bit stuff);
    for (int i = 0; i < n; i++) begin
      bitOut(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        bitOut(1'b0);
        ones = 0;
      end
    end
  endtask : sendBits
  task automatic frame(input logic [7:0] adr, input logic [7:0] dat, input bit abort);
    sendBits(8'h7E, 8, 0);
    sendBits(adr, 8, 1);
    if (abort) sendBits(8'h7F, 7, 0);
    else begin
      sendBits(dat, 8, 1);
      sendBits(8'h7E, 8, 0);
    end
    serialIn = ~serialIn;
  endtask : frame
endmodule : bbp_station

// >>> sim/testbench.sv
/* self-checking bench of the frame controller with a remote station model
   assumes package, checker and station compiled before it */
`timescale 1ns/1ns
module testbench;
  import bbp_pkg::*;
  logic mclk, rst, strobe, txEn, rxEn, txRun, txClk, rxClk, serIn, oePrev;
  bbp_bus_t bus;
  bbp_line_t line;
  logic [15:0] busDataOut, p;
  logic busDataOe, serialOutput, txBufferEmpty, txUnderrunOutput;
  logic rxDataAvail, rxStatusAvail, receiverActive;
  logic [7:0] txSeen, a, d, x;
  logic [31:0] n;
  logic [31:0] notes[$];
  int error_cnt, checks;
  assign line = {strobe, txClk, rxClk, serIn, txEn, rxEn};
  bbp_frame_ctrl #(.RX_DEPTH(16)) dut_u (.mclk, .rst, .clkEn(1'b1), .hostBus(bus), .lineIn(line),
    .busDataOut, .busDataOe, .serialOutput, .txBufferEmpty, .txUnderrunOutput, .rxDataAvail,
    .rxStatusAvail, .receiverActive);
  bbp_station station_u (.serialOutput, .txRun, .txBitClock(txClk), .rxBitClock(rxClk),
    .serialIn(serIn), .txSeen);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    checks++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [2:0] ad, input logic bs, input logic [15:0] v,
    input logic [15:0] m);
    @(posedge mclk);
    #2;
    bus = {1'b1, ad, bs, wr, v};
    strobe = 1'b1;
    if (!wr) notes.push_back({m, v});
    repeat (6) @(posedge mclk);
    #2;
    strobe = 1'b0;
    repeat (6) @(posedge mclk);
    #2;
  endtask : acc
  task automatic conclude();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  always @(posedge mclk) begin
    oePrev <= busDataOe;
    if (busDataOe === 1'b1 && oePrev === 1'b0 && notes.size() > 0) begin
      n = notes.pop_front();
      chk(busDataOut, n[15:0], n[31:16]);
    end
  end
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #1500000;
    error_cnt++;
    conclude();
  end
  initial begin
    {rst, strobe, txEn, rxEn, txRun} = 5'b10000;
    bus = '0;
    repeat (12) @(posedge mclk);
    #2;
    rst = 1'b0;
    void'($urandom(26599));
    a = $urandom;
    d = $urandom;
    chk({serialOutput, txBufferEmpty, txUnderrunOutput, busDataOe}, 16'h000C, 16'h000F);
    for (int k = 0; k < 2; k++) begin
      x = k ? 8'hFF : a;
      p = {k[0], 4'b0010, 3'b111, a};
      acc(1'b1, 3'b100, 1'b0, p, 16'h0000);
      acc(1'b0, 3'b100, 1'b0, p, 16'hFFFF);
      rxEn = 1'b1;
      station_u.frame(x, d, 1'b0);
      chk({13'h0, rxDataAvail, rxStatusAvail, receiverActive}, 16'h0006, 16'h0007);
      acc(1'b0, 3'b000, 1'b1, {x, x}, 16'hFFFF);
      acc(1'b0, 3'b000, 1'b1, {d, d}, 16'hFFFF);
      acc(1'b0, 3'b001, 1'b1, 16'h0202, 16'hFEFE);
      rxEn = 1'b0;
      repeat (8) @(posedge mclk);
    end
    #2;
    rxEn = 1'b1;
    station_u.frame(a, d, 1'b1);
    chk({15'h0, rxDataAvail}, 16'h0000, 16'h0001);
    acc(1'b0, 3'b000, 1'b1, {d, d}, 16'hFFFF);
    acc(1'b0, 3'b001, 1'b1, 16'h0606, 16'h0606);
    txEn = 1'b1;
    txRun = 1'b1;
    acc(1'b1, 3'b010, 1'b0, {8'h01, d}, 16'h0000);
    for (int i = 0; i < 2000 && txSeen !== 8'h7E; i++) @(posedge mclk);
    chk({8'h00, txSeen}, 16'h007E, 16'h00FF);
    acc(1'b1, 3'b010, 1'b0, {8'h00, d}, 16'h0000);
    for (int i = 0; i < 4000 && txUnderrunOutput !== 1'b1; i++) @(posedge mclk);
    chk({15'h0, txUnderrunOutput}, 16'h0001, 16'h0001);
    acc(1'b0, 3'b010, 1'b0, 16'h8000, 16'h8000);
    acc(1'b1, 3'b010, 1'b0, 16'h0100, 16'h0000);
    for (int i = 0; i < 1000 && txUnderrunOutput !== 1'b0; i++) @(posedge mclk);
    chk({15'h0, txUnderrunOutput}, 16'h0000, 16'h0001);
    acc(1'b0, 3'b010, 1'b0, 16'h0000, 16'h8000);
    repeat (20) @(posedge mclk);
    chk(16'(notes.size()), 16'h0000, 16'hFFFF);
    conclude();
  end
endmodule : testbench

// >>> src/bbp_frame_ctrl.sv
/*
  Receive FIFO and top module of the bit/byte protocol frame controller.
  Assumes the host bus and line pins are asynchronous to mclk and slower than a
  few mclk periods per edge; bit clocks are sampled and edge-detected on mclk.
*/
// Overview of operation
// - all-parties bit also accepts an all-ones address field in bit mode
// - protocol bit 0 selects bit-oriented, 1 byte-oriented framing
// - a message starts only when start is set with transmit enable high
// - bit mode sends flags while start is set, then data with check
// - byte mode start sends sync byte or holding byte by fill select
// - bit mode end sends check then flags, or abort or go-ahead instead
// - byte mode end sends CRC-16 then sync or holding byte by fill select
// - end cleared before CRC-16 done holds line at mark after CRC
// - abort sends seven ones or flags; go-ahead replaces the closing flag
// - late holding reload sets the error bit and underrun; start clears it
// - underrun fill: abort or flag in bit mode, sync or mark in byte mode
// - underrun output rises on falling bit edge, drops on edge after start
// - with end cleared and enable high, empty holding gives underrun
// - receive holding byte presents each character, parity bit removed
// - receive start sets on accepted address, drives active, lasts one char
// - receive end sets on closing flag or abort; clears on status read
// - abort/go-ahead flag on seven received ones in bit mode; a received abort gives no data
// - overrun sets when no room for a character; character is lost
// - assembled count gives residual bits, right-justified, zero on boundary
// - CCITT error bit in bit mode is remainder unequal to F0B8 or zero per preset
// - CRC-16 error bit is one for zero remainder in byte mode, nonzero in bit mode; parity one on error
// - fill select chooses abort or flag as bit mode fill and abort
// - a write to either transmit byte clears buffer-empty
// - strobe trailing edge of low read clears data available, of high status read status available
`timescale 1ns/1ns
`include "bbp_map.svh"

module bbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
    $error("fifo depth must be a power of two of at least 2");
  end

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (clkEn && push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (clkEn) begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= rdPtr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end
endmodule : bbp_fifo

module bbp_frame_ctrl #(
  parameter int RX_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire bbp_pkg::bbp_bus_t hostBus,
  input wire bbp_pkg::bbp_line_t lineIn,
  output logic [15:0] busDataOut,
  output logic busDataOe,
  output logic serialOutput,
  output logic txBufferEmpty,
  output logic txUnderrunOutput,
  output logic rxDataAvail,
  output logic rxStatusAvail,
  output logic receiverActive
);
  import bbp_pkg::*;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b,
                                          input logic [15:0] poly);
    crcStep = (c[0] ^ b) ? ((c >> 1) ^ poly) : (c >> 1);
  endfunction : crcStep

  function automatic logic [4:0] lenOf(input logic [2:0] code);
    lenOf = (code == 3'b000) ? 5'd8 : {2'b00, code};
  endfunction : lenOf

  // synchronisers and edges
  logic [$bits(bbp_bus_t)+$bits(bbp_line_t)-1:0] syncA_r, syncB_r;
  bbp_bus_t bus;
  bbp_line_t ln, lnD_r;
  assign {bus, ln} = syncB_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
      lnD_r <= '0;
    end else if (clkEn) begin
      syncA_r <= {hostBus, lineIn};
      syncB_r <= syncA_r;
      lnD_r <= ln;
    end
  end

  logic strobeRise, strobeFall, txFall, rxRise;
  assign strobeRise = ln.dataStrobe && !lnD_r.dataStrobe;
  assign strobeFall = !ln.dataStrobe && lnD_r.dataStrobe;
  assign txFall = !ln.txBitClock && lnD_r.txBitClock;
  assign rxRise = ln.rxBitClock && !lnD_r.rxBitClock;

  // registers
  logic [15:0] psa_r;
  logic [7:0] txHold_r, rxHold_r;
  logic txSom_r, txEom_r, txAbt_r, txGa_r, txErr_r;
  logic [2:0] rxCl_r, txCl_r, abc_r;
  logic rxSom_r, rxEom_r, rxAbGa_r, rxOvr_r, rxErr_r;
  logic rdLo_r, rdHi_r;

  logic bit_oriented_protocol, fill, crcMode, vrcMode;
  logic [15:0] preset, poly;
  assign bit_oriented_protocol = (psa_r[`BBP_PS_PROTOCOL_SELECT] == `BBP_PROTOCOL_SELECT_BOP);
  assign fill = psa_r[`BBP_PS_FILL];
  assign crcMode = psa_r[`BBP_PS_ECM] == `BBP_ECM_CCITT1 || psa_r[`BBP_PS_ECM] == `BBP_ECM_CCITT0
                   || psa_r[`BBP_PS_ECM] == `BBP_ECM_CRC16;
  assign vrcMode = psa_r[`BBP_PS_ECM] == `BBP_ECM_VRC_ODD
                   || psa_r[`BBP_PS_ECM] == `BBP_ECM_VRC_EVEN;
  assign preset = (psa_r[`BBP_PS_ECM] == `BBP_ECM_CCITT1) ? `BBP_PRESET1 : `BBP_PRESET0;
  assign poly = (psa_r[`BBP_PS_ECM] == `BBP_ECM_CRC16) ? `BBP_POLY_CRC16 : `BBP_POLY_CCITT;

  logic [1:0] idx;
  logic hiSel, loSel, wrEvt, rdEvt;
  assign idx = bus.addr[2:1];
  assign hiSel = !bus.byteSel || bus.addr[0];
  assign loSel = !bus.byteSel || !bus.addr[0];
  assign wrEvt = strobeRise && bus.chipEn && bus.writeNotRead;
  assign rdEvt = strobeRise && bus.chipEn && !bus.writeNotRead;

  logic [15:0] rdWord;
  always_comb begin
    unique case (idx)
      `BBP_IDX_RDS: rdWord = {rxErr_r, abc_r, rxOvr_r, rxAbGa_r, rxEom_r, rxSom_r, rxHold_r};
      `BBP_IDX_TDS: rdWord = {txErr_r, 3'b000, txGa_r, txAbt_r, txEom_r, txSom_r, txHold_r};
      `BBP_IDX_PSA: rdWord = psa_r;
      `BBP_IDX_PCR: rdWord = {txCl_r, 2'b00, rxCl_r, `BBP_RST8};
    endcase
  end

  // host read: capture at leading edge, drive until trailing edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      busDataOut <= `BBP_RST16;
      busDataOe <= 1'b0;
      rdLo_r <= 1'b0;
      rdHi_r <= 1'b0;
    end else if (clkEn) begin
      if (rdEvt) begin
        busDataOe <= 1'b1;
        rdLo_r <= (idx == `BBP_IDX_RDS) && loSel;
        rdHi_r <= (idx == `BBP_IDX_RDS) && hiSel;
        if (!bus.byteSel) busDataOut <= rdWord;
        else if (bus.addr[0]) busDataOut <= {rdWord[15:8], rdWord[15:8]};
        else busDataOut <= {rdWord[7:0], rdWord[7:0]};
      end else if (strobeFall) begin
        busDataOe <= 1'b0;
        rdLo_r <= 1'b0;
        rdHi_r <= 1'b0;
      end
    end
  end

  logic hiDone, loDone;
  assign hiDone = strobeFall && rdHi_r;
  assign loDone = strobeFall && rdLo_r;

  // transmitter character choice at each boundary
  bbp_tx_state_t txState_r, txStateNxt;
  bbp_tx_char_t txSel, closeChar, abortFill, syncFill;
  logic [15:0] txCrc_r, txSh_r;
  logic [4:0] txLeft_r;
  logic [2:0] txOnes_r;
  logic txStuff_r, txCrcOn_r, tx_buffer_empty_r, goData, txBit, stuffNow;
  logic [4:0] txLen;
  assign txLen = lenOf(txCl_r);

  always_comb begin
    abortFill = '0;
    abortFill.bits = fill ? {8'h00, `BBP_FLAG} : `BBP_ABORT;
    abortFill.len = fill ? `BBP_FLAG_LEN : `BBP_PAT7_LEN;
    syncFill = '0;
    syncFill.bits = {8'h00, fill ? txHold_r : psa_r[`BBP_PS_ADDR]};
    syncFill.len = txLen;
    syncFill.takeHold = fill;
    closeChar = '0;
    if (bit_oriented_protocol) begin
      closeChar.bits = {8'h00, `BBP_FLAG};
      closeChar.len = `BBP_FLAG_LEN;
      if (txGa_r) begin
        closeChar.bits = `BBP_GOAHEAD;
        closeChar.len = `BBP_PAT7_LEN;
      end else if (txAbt_r) begin
        closeChar = abortFill;
      end
    end else begin
      closeChar = syncFill;
    end
  end

  always_comb begin
    txSel = '0;
    txSel.bits = `BBP_MARK;
    txSel.len = 5'd1;
    txStateNxt = txState_r;
    goData = 1'b0;
    unique case (txState_r)
      TX_IDLE: if (ln.txEnable && txSom_r) txStateNxt = TX_OPEN;
      TX_OPEN, TX_DATA: begin
        if (!txSom_r) goData = 1'b1;
        else if (bit_oriented_protocol) begin
          txSel.bits = {8'h00, `BBP_FLAG};
          txSel.len = `BBP_FLAG_LEN;
        end else txSel = syncFill;
        if (txSom_r) txStateNxt = TX_OPEN;
      end
      TX_CLOSE: begin
        if (txEom_r) txSel = closeChar;
        else if (bit_oriented_protocol) txStateNxt = TX_OPEN;
        else txStateNxt = TX_MARK;
      end
      TX_MARK: txStateNxt = TX_MARK;
      default: txStateNxt = TX_IDLE;
    endcase
    if (goData) begin
      txStateNxt = TX_DATA;
      if (bit_oriented_protocol && txAbt_r) begin
        txSel = abortFill;
        txStateNxt = TX_OPEN;
      end else if (!tx_buffer_empty_r) begin
        txSel.bits = {8'h00, txHold_r};
        txSel.len = txLen;
        txSel.stuff = bit_oriented_protocol;
        txSel.crcOn = crcMode;
        txSel.takeHold = 1'b1;
        txSel.crcInit = (txState_r == TX_OPEN);
      end else if (txEom_r) begin
        txStateNxt = TX_CLOSE;
        if (crcMode) begin
          txSel.bits = (preset == `BBP_PRESET1) ? ~txCrc_r : txCrc_r;
          txSel.len = `BBP_CRC_LEN;
          txSel.stuff = bit_oriented_protocol;
        end else txSel = closeChar;
      end else begin
        txSel = bit_oriented_protocol ? abortFill : syncFill;
        if (!bit_oriented_protocol && fill) begin
          txSel.bits = `BBP_MARK;
          txSel.takeHold = 1'b0;
        end
        txSel.underrun = 1'b1;
      end
    end
    if (!ln.txEnable) begin
      txSel = '0;
      txSel.bits = `BBP_MARK;
      txSel.len = 5'd1;
      txStateNxt = TX_IDLE;
    end
  end

  assign stuffNow = txStuff_r && (txOnes_r == `BBP_STUFF_RUN);
  assign txBit = stuffNow ? 1'b0 : ((txLeft_r == '0) ? txSel.bits[0] : txSh_r[0]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      txState_r <= TX_IDLE;
      txSh_r <= `BBP_MARK;
      txLeft_r <= '0;
      txOnes_r <= '0;
      txStuff_r <= 1'b0;
      txCrcOn_r <= 1'b0;
      txCrc_r <= `BBP_PRESET0;
      serialOutput <= 1'b1;
      txUnderrunOutput <= 1'b0;
    end else if (clkEn && txFall) begin
      serialOutput <= txBit;
      txOnes_r <= (txBit && txStuff_r) ? txOnes_r + 1'b1 : '0;
      if (!stuffNow && txLeft_r == '0) begin
        txState_r <= txStateNxt;
        txSh_r <= txSel.bits >> 1;
        txLeft_r <= txSel.len - 1'b1;
        txStuff_r <= txSel.stuff;
        txCrcOn_r <= txSel.crcOn;
        if (txSel.crcOn) txCrc_r <= crcStep(txSel.crcInit ? preset : txCrc_r, txBit, poly);
        if (txSel.underrun) txUnderrunOutput <= 1'b1;
        else if (txSom_r) txUnderrunOutput <= 1'b0;
      end else begin
        if (!stuffNow) begin
          txSh_r <= txSh_r >> 1;
          txLeft_r <= txLeft_r - 1'b1;
          if (txCrcOn_r) txCrc_r <= crcStep(txCrc_r, txBit, poly);
        end
        if (txSom_r) txUnderrunOutput <= 1'b0;
      end
    end
  end

  logic txLoadTake, txLoadUnder;
  assign txLoadTake = txFall && !stuffNow && txLeft_r == '0 && txSel.takeHold;
  assign txLoadUnder = txFall && !stuffNow && txLeft_r == '0 && txSel.underrun;

  // host writes, transmit flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      psa_r <= `BBP_RST16;
      txHold_r <= `BBP_RST8;
      {txSom_r, txEom_r, txAbt_r, txGa_r} <= 4'b0000;
      rxCl_r <= `BBP_RST3;
      txCl_r <= `BBP_RST3;
      txErr_r <= 1'b0;
      tx_buffer_empty_r <= 1'b1;
    end else if (clkEn) begin
      if (txLoadTake) tx_buffer_empty_r <= 1'b1;
      if (txLoadUnder) txErr_r <= 1'b1;
      else if (wrEvt && idx == `BBP_IDX_TDS && hiSel && bus.data[`BBP_TX_SOM]) txErr_r <= 1'b0;
      if (wrEvt) begin
        unique case (idx)
          `BBP_IDX_RDS: ;
          `BBP_IDX_TDS: begin
            tx_buffer_empty_r <= 1'b0;
            if (loSel) txHold_r <= bus.data[`BBP_TX_HOLD];
            if (hiSel) begin
              txSom_r <= bus.data[`BBP_TX_SOM];
              txEom_r <= bus.data[`BBP_TX_EOM];
              txAbt_r <= bus.data[`BBP_TX_ABT];
              txGa_r <= bus.data[`BBP_TX_GA];
            end
          end
          `BBP_IDX_PSA: begin
            if (loSel) psa_r[7:0] <= bus.data[7:0];
            if (hiSel) psa_r[15:8] <= bus.data[15:8];
          end
          `BBP_IDX_PCR: if (hiSel) begin
            if (!bus.data[`BBP_PCR_RXCLE]) rxCl_r <= bus.data[`BBP_PCR_RXCL];
            if (!bus.data[`BBP_PCR_TXCLE]) txCl_r <= bus.data[`BBP_PCR_TXCL];
          end
        endcase
      end
    end
  end
  assign txBufferEmpty = tx_buffer_empty_r;

  // receiver bit decode
  bbp_rx_state_t rxState_r;
  logic [2:0] rxOnes_r, dlyCnt_r, asmCnt_r;
  logic [6:0] dly_r;
  logic [7:0] asm_r, asmNew, charVal, pushData_r;
  logic [15:0] rxCrc_r, crcNew;
  logic [4:0] rxLen;
  logic rb, abEvt, flagEvt, asmValid, asmBit, charDone, addrOk, parityBad, strip_r;
  logic pushValid_r, fifoReady, fifoValid;
  logic [7:0] fifoData;

  assign rxLen = lenOf(rxCl_r);
  assign rb = ln.serialIn;
  assign abEvt = bit_oriented_protocol && rb && rxOnes_r == `BBP_FLAG_RUN;
  assign flagEvt = bit_oriented_protocol && !rb && rxOnes_r == `BBP_FLAG_RUN;
  assign asmBit = bit_oriented_protocol ? dly_r[0] : rb;
  assign asmValid = bit_oriented_protocol ? (!abEvt && !flagEvt && !(!rb && rxOnes_r == `BBP_STUFF_RUN)
                           && dlyCnt_r == `BBP_DLY_FULL) : 1'b1;
  assign asmNew = {asmBit, asm_r[7:1]};
  assign charDone = asmValid && ({2'b00, asmCnt_r} + 5'd1 == rxLen);
  assign charVal = asmNew >> (5'd8 - rxLen);
  assign crcNew = crcStep(rxCrc_r, asmBit, poly);
  assign addrOk = !psa_r[`BBP_PS_SAM] || charVal == psa_r[`BBP_PS_ADDR]
                  || (psa_r[`BBP_PS_APA] && charVal == `BBP_ALL_ONES);
  assign parityBad = (^charVal) == (psa_r[`BBP_PS_ECM] == `BBP_ECM_VRC_EVEN);

  always_ff @(posedge mclk) begin
    if (rst || (clkEn && !ln.rxEnable)) begin
      rxState_r <= RX_HUNT;
      {rxOnes_r, dlyCnt_r, asmCnt_r} <= '0;
      dly_r <= '0;
      asm_r <= `BBP_RST8;
      rxCrc_r <= `BBP_PRESET0;
      strip_r <= 1'b0;
      pushValid_r <= 1'b0;
      pushData_r <= `BBP_RST8;
      {rxSom_r, rxEom_r, rxAbGa_r, rxOvr_r, rxErr_r} <= '0;
      abc_r <= `BBP_RST3;
      rxStatusAvail <= 1'b0;
      receiverActive <= 1'b0;
    end else if (clkEn) begin
      pushValid_r <= 1'b0;
      if (hiDone) begin
        {rxEom_r, rxAbGa_r, rxOvr_r} <= 3'b000;
        abc_r <= `BBP_RST3;
        rxStatusAvail <= 1'b0;
      end
      if (pushValid_r && !fifoReady) begin
        rxOvr_r <= 1'b1;
        rxStatusAvail <= 1'b1;
      end
      if (rxRise) begin
        rxOnes_r <= (bit_oriented_protocol && rb) ? ((rxOnes_r == `BBP_DLY_FULL) ? rxOnes_r : rxOnes_r + 1'b1)
                                : '0;
        if (bit_oriented_protocol && (rb || rxOnes_r != `BBP_STUFF_RUN)) begin
          dly_r <= {rb, dly_r[6:1]};
          if (dlyCnt_r != `BBP_DLY_FULL) dlyCnt_r <= dlyCnt_r + 1'b1;
        end
        if (asmValid) begin
          asm_r <= asmNew;
          asmCnt_r <= charDone ? '0 : asmCnt_r + 1'b1;
          if (rxState_r != RX_HUNT) rxCrc_r <= crcNew;
        end
        if (charDone && rxSom_r) rxSom_r <= 1'b0;
        if (flagEvt || abEvt) begin
          {dlyCnt_r, asmCnt_r} <= '0;
          rxCrc_r <= preset;
          rxState_r <= abEvt ? RX_HUNT : RX_ADDR;
          receiverActive <= 1'b0;
          if (rxState_r == RX_FRAME || abEvt) begin
            rxEom_r <= 1'b1;
            rxStatusAvail <= 1'b1;
          end
          if (abEvt) rxAbGa_r <= 1'b1;
          else if (rxState_r == RX_FRAME) begin
            abc_r <= asmCnt_r;
            if (crcMode) rxErr_r <= rxCrc_r
                                    != ((preset == `BBP_PRESET1) ? `BBP_RESIDUE : `BBP_PRESET0);
            if (asmCnt_r != '0) begin
              pushData_r <= asm_r >> (4'd8 - {1'b0, asmCnt_r});
              pushValid_r <= 1'b1;
            end
          end
        end else if (!bit_oriented_protocol && rxState_r == RX_HUNT) begin
          if (charVal == (psa_r[`BBP_PS_ADDR] & (`BBP_ALL_ONES >> (5'd8 - rxLen)))) begin
            rxState_r <= RX_FRAME;
            asmCnt_r <= '0;
            rxCrc_r <= preset;
            strip_r <= 1'b1;
          end
        end else if (charDone) begin
          unique case (rxState_r)
            RX_HUNT, RX_DROP: ;
            RX_ADDR: begin
              rxState_r <= addrOk ? RX_FRAME : RX_DROP;
              if (addrOk) begin
                rxSom_r <= 1'b1;
                receiverActive <= 1'b1;
                pushData_r <= charVal;
                pushValid_r <= 1'b1;
              end
            end
            RX_FRAME: begin
              if (!(strip_r && psa_r[`BBP_PS_STRIP] && !bit_oriented_protocol
                    && charVal == psa_r[`BBP_PS_ADDR])) begin
                strip_r <= 1'b0;
                pushValid_r <= 1'b1;
                pushData_r <= vrcMode ? (charVal & (`BBP_ALL_ONES >> (5'd9 - rxLen)))
                                      : charVal;
                if (vrcMode && parityBad) begin
                  rxErr_r <= 1'b1;
                  rxStatusAvail <= 1'b1;
                end
                if (!bit_oriented_protocol && psa_r[`BBP_PS_ECM] == `BBP_ECM_CRC16) rxErr_r <= crcNew == '0;
              end
            end
          endcase
        end
      end
    end
  end

  bbp_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) rxFifo (
    .mclk(mclk),
    .rst(rst || (clkEn && !ln.rxEnable)),
    .clkEn(clkEn),
    .inData(pushData_r),
    .inValid(pushValid_r),
    .inReady(fifoReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(!rxDataAvail)
  );

  // receive holding byte
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxHold_r <= `BBP_RST8;
      rxDataAvail <= 1'b0;
    end else if (clkEn) begin
      if (fifoValid && !rxDataAvail) begin
        rxHold_r <= fifoData;
        rxDataAvail <= 1'b1;
      end else if (loDone) rxDataAvail <= 1'b0;
    end
  end
endmodule : bbp_frame_ctrl

// >>> src/bbp_map.svh
/*
  Register offsets, field positions, reset values, bit patterns and check constants
  of the bit/byte protocol frame controller.
  Assumes it is included by bare name by the package and by the design file.
*/
`ifndef BBP_MAP_SVH
`define BBP_MAP_SVH

// word index, address bits 2:1
`define BBP_IDX_RDS 2'b00
`define BBP_IDX_TDS 2'b01
`define BBP_IDX_PSA 2'b10
`define BBP_IDX_PCR 2'b11

// transmit_data_and_status fields
`define BBP_TX_HOLD 7:0
`define BBP_TX_SOM 8
`define BBP_TX_EOM 9
`define BBP_TX_ABT 10
`define BBP_TX_GA 11

// sync_address_parameters fields
`define BBP_PS_ADDR 7:0
`define BBP_PS_ECM 10:8
`define BBP_PS_FILL 11
`define BBP_PS_SAM 12
`define BBP_PS_STRIP 13
`define BBP_PS_PROTOCOL_SELECT 14
`define BBP_PS_APA 15

// character_length_parameters fields
`define BBP_PCR_RXCL 10:8
`define BBP_PCR_RXCLE 11
`define BBP_PCR_TXCLE 12
`define BBP_PCR_TXCL 15:13

// reset values
`define BBP_RST16 16'h0000
`define BBP_RST8 8'h00
`define BBP_RST3 3'b000

// line patterns, first bit in bit 0
`define BBP_FLAG 8'h7E
`define BBP_ABORT 16'h007F
`define BBP_GOAHEAD 16'h007E
`define BBP_MARK 16'hFFFF
`define BBP_ALL_ONES 8'hFF
`define BBP_FLAG_LEN 5'd8
`define BBP_PAT7_LEN 5'd7
`define BBP_CRC_LEN 5'd16
`define BBP_STUFF_RUN 3'd5
`define BBP_FLAG_RUN 3'd6
`define BBP_DLY_FULL 3'd7

// error control modes
`define BBP_ECM_CCITT1 3'b000
`define BBP_ECM_CCITT0 3'b001
`define BBP_ECM_CRC16 3'b011
`define BBP_ECM_VRC_ODD 3'b100
`define BBP_ECM_VRC_EVEN 3'b101
`define BBP_POLY_CCITT 16'h8408
`define BBP_POLY_CRC16 16'hA001
`define BBP_RESIDUE 16'hF0B8
`define BBP_PRESET1 16'hFFFF
`define BBP_PRESET0 16'h0000
`define BBP_PROTOCOL_SELECT_BOP 1'b0

`endif

// >>> src/bbp_pkg.sv
/*
  Types of the bit/byte protocol frame controller: host bus and line carriers,
  state encodings and the transmit character descriptor.
  Assumes bbp_map.svh is on the include path.
*/
`include "bbp_map.svh"
package bbp_pkg;
  typedef struct packed {
    logic chipEn;
    logic [2:0] addr;
    logic byteSel;
    logic writeNotRead;
    logic [15:0] data;
  } bbp_bus_t;

  typedef struct packed {
    logic dataStrobe;
    logic txBitClock;
    logic rxBitClock;
    logic serialIn;
    logic txEnable;
    logic rxEnable;
  } bbp_line_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_OPEN = 3'b001,
    TX_DATA = 3'b010,
    TX_CLOSE = 3'b011,
    TX_MARK = 3'b100
  } bbp_tx_state_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_ADDR = 2'b01,
    RX_FRAME = 2'b10,
    RX_DROP = 2'b11
  } bbp_rx_state_t;

  typedef struct packed {
    logic [15:0] bits;
    logic [4:0] len;
    logic stuff;
    logic crcOn;
    logic crcInit;
    logic takeHold;
    logic underrun;
  } bbp_tx_char_t;
endpackage : bbp_pkg
